// ==== core/hpem_regs.svh ====
// Offsets, field positions and reset values of the hub port map configuration registers.
`ifndef HPEM_REGS_SVH
`define HPEM_REGS_SVH

// ====================================================================
// Register offsets
`define HPEM_OFS_NUMBERING_CFG   16'h00E6
`define HPEM_OFS_FIXED_MASK      16'h00E7
`define HPEM_OFS_SELF_OFF_MASK   16'h00E8
`define HPEM_OFS_BUS_OFF_MASK    16'h00E9
`define HPEM_OFS_EXT_SELF_OFF    16'h300A
`define HPEM_OFS_EXT_BUS_OFF     16'h300B
`define HPEM_OFS_REMAP_PAIR      16'h30FB
`define HPEM_OFS_REMAP_THIRD     16'h30FC
`define HPEM_OFS_DEFAULT_CTRL    16'h30F0
`define HPEM_OFS_STATUS          16'h30F1

// ====================================================================
// Field positions
`define HPEM_BIT_REMAP_SEL       3
`define HPEM_PORT_HI             3
`define HPEM_PORT_LO             1
`define HPEM_BIT_STRAP_SEL       0
`define HPEM_MAP1_HI             3
`define HPEM_MAP1_LO             0
`define HPEM_MAP2_HI             7
`define HPEM_MAP2_LO             4

// ====================================================================
// Reset values
`define HPEM_RST_REMAP_SEL       1'h0
`define HPEM_RST_PORT_MASK       3'h0
`define HPEM_RST_REMAP           8'h00
`define HPEM_RST_STRAP_SEL       1'h1
`define HPEM_RST_RDATA           8'h00

`endif

// ==== core/hpem_pkg.sv ====
// Types and shared helpers of the hub port map configuration block.
package hpem_pkg;

	typedef logic [2:0] hpem_ports_t;
	typedef logic [3:0] hpem_lport_t;

	typedef struct packed {
		hpem_lport_t p3;
		hpem_lport_t p2;
		hpem_lport_t p1;
	} hpem_lmap_t;

	typedef struct packed {
		hpem_ports_t enable;
		hpem_ports_t fixed;
		logic [1:0]  count;
		hpem_lmap_t  lmap;
	} hpem_report_t;

	function automatic logic [1:0] hpem_count3(input hpem_ports_t m);
		hpem_count3 = {1'b0, m[0]} + {1'b0, m[1]} + {1'b0, m[2]};
	endfunction : hpem_count3

endpackage : hpem_pkg

// ==== core/hpem_renumber.sv ====
// Logical port numbering for the three downstream ports, registered.
`timescale 1ns/1ps
module hpem_renumber
	import hpem_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire hpem_ports_t enable,
	input  wire logic        remap_mode,
	input  wire hpem_lmap_t  remap,
	output hpem_lmap_t       lmap,
	output logic [1:0]       count
);

	// ====================================================================
	// Next values
	hpem_lmap_t  next_lmap;
	hpem_ports_t live;
	logic [1:0]  c1;
	logic [1:0]  c2;
	logic [1:0]  c3;

	always_comb
	begin
		live = enable;
		if (remap_mode)
		begin
			live = enable & {remap.p3 != 4'h0, remap.p2 != 4'h0, remap.p1 != 4'h0};
		end
		c1 = hpem_count3({2'b00, live[0]});
		c2 = hpem_count3({1'b0, live[1:0]});
		c3 = hpem_count3(live);
		if (remap_mode)
		begin
			next_lmap.p1 = live[0] ? remap.p1 : 4'h0;
			next_lmap.p2 = live[1] ? remap.p2 : 4'h0;
			next_lmap.p3 = live[2] ? remap.p3 : 4'h0;
		end
		else
		begin
			// A disabled port pulls every higher enabled port down by one.
			next_lmap.p1 = live[0] ? {2'b00, c1} : 4'h0;
			next_lmap.p2 = live[1] ? {2'b00, c2} : 4'h0;
			next_lmap.p3 = live[2] ? {2'b00, c3} : 4'h0;
		end
	end

	// ====================================================================
	// Registers
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			lmap  <= '0;
			count <= 2'h0;
		end
		else
		begin
			lmap  <= next_lmap;
			count <= c3;
		end
	end

endmodule : hpem_renumber

// ==== core/hpem_top.sv ====
// Port enable, numbering and non-removable configuration of a three-port hub.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "hpem_regs.svh"

// Functional notes
// - Bit 3 of the numbering config selects standard (0) or explicit remap (1).
// - Standard mode, nothing disabled: physical port n is reported as logical n.
// - Standard mode: higher enabled ports shift down to keep numbers contiguous.
// - Standard mode enables come from straps or the off masks ORed with the extended off registers, reset zero.
// - Remap mode takes logical numbers from the two remap registers, reset zero.
// - Per-port non-removable mask, one means fixed, reported to the host.
// - Bits 3..1 of the masks steer ports 3..1; other bits reserved.
// - Internal defaults take fixed ports from a two-bit strap field.
// - Self-powered: ports set in the self-powered off mask stay disabled.
// - Any disable combination works; count and order of ports stay correct.
// - Bus-powered: the bus-powered off mask applies, same encoding.
// - Internal defaults take disabled ports from a two-bit strap field.
// - The power mode picks which of the two off masks is in effect.
module hpem_top
	import hpem_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [7:0]  rdata,
	input  wire logic        self_powered_pin,
	input  wire logic [1:0]  strap_fixed_device_bits,
	input  wire logic [1:0]  strap_port_off_bits,
	output hpem_report_t     port_report
);

	// ====================================================================
	// Helpers

	// Strap field k marks the lowest k ports.
	function automatic hpem_ports_t hpem_low_ports(input logic [1:0] k);
		case (k)
			2'h0:    hpem_low_ports = 3'h0;
			2'h1:    hpem_low_ports = 3'h1;
			2'h2:    hpem_low_ports = 3'h3;
			default: hpem_low_ports = 3'h7;
		endcase
	endfunction : hpem_low_ports

	// Mask register readback with reserved bits at zero.
	function automatic logic [7:0] hpem_mask_read(input hpem_ports_t m);
		hpem_mask_read = {4'h0, m, 1'b0};
	endfunction : hpem_mask_read

	// ====================================================================
	// Pin synchronisers
	logic       sp_sync1;
	logic       sp_sync2;
	logic [1:0] fix_sync1;
	logic [1:0] fix_sync2;
	logic [1:0] off_sync1;
	logic [1:0] off_sync2;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			sp_sync1  <= 1'b0;
			sp_sync2  <= 1'b0;
			fix_sync1 <= 2'h0;
			fix_sync2 <= 2'h0;
			off_sync1 <= 2'h0;
			off_sync2 <= 2'h0;
		end
		else
		begin
			sp_sync1  <= self_powered_pin;
			sp_sync2  <= sp_sync1;
			fix_sync1 <= strap_fixed_device_bits;
			fix_sync2 <= fix_sync1;
			off_sync1 <= strap_port_off_bits;
			off_sync2 <= off_sync1;
		end
	end

	// ====================================================================
	// Register file
	logic        explicit_remap_select;
	hpem_ports_t fixed_device_port_mask;
	hpem_ports_t self_power_port_off_mask;
	hpem_ports_t bus_power_port_off_mask;
	hpem_ports_t ext_self_power_port_off;
	hpem_ports_t ext_bus_power_port_off;
	logic [7:0]  port_remap_first_pair;
	logic [7:0]  port_remap_third;
	logic        strap_default_sel;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			explicit_remap_select <= `HPEM_RST_REMAP_SEL;
		end
		else if (wr_en && addr == `HPEM_OFS_NUMBERING_CFG)
		begin
			explicit_remap_select <= wdata[`HPEM_BIT_REMAP_SEL];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			strap_default_sel <= `HPEM_RST_STRAP_SEL;
		end
		else if (wr_en && addr == `HPEM_OFS_DEFAULT_CTRL)
		begin
			strap_default_sel <= wdata[`HPEM_BIT_STRAP_SEL];
		end
	end

	// Only bits 3..1 are stored, so reserved bits can never be written.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			fixed_device_port_mask <= `HPEM_RST_PORT_MASK;
		end
		else if (wr_en && addr == `HPEM_OFS_FIXED_MASK)
		begin
			fixed_device_port_mask <= wdata[`HPEM_PORT_HI:`HPEM_PORT_LO];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			self_power_port_off_mask <= `HPEM_RST_PORT_MASK;
		end
		else if (wr_en && addr == `HPEM_OFS_SELF_OFF_MASK)
		begin
			self_power_port_off_mask <= wdata[`HPEM_PORT_HI:`HPEM_PORT_LO];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			bus_power_port_off_mask <= `HPEM_RST_PORT_MASK;
		end
		else if (wr_en && addr == `HPEM_OFS_BUS_OFF_MASK)
		begin
			bus_power_port_off_mask <= wdata[`HPEM_PORT_HI:`HPEM_PORT_LO];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ext_self_power_port_off <= `HPEM_RST_PORT_MASK;
		end
		else if (wr_en && addr == `HPEM_OFS_EXT_SELF_OFF)
		begin
			ext_self_power_port_off <= wdata[`HPEM_PORT_HI:`HPEM_PORT_LO];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ext_bus_power_port_off <= `HPEM_RST_PORT_MASK;
		end
		else if (wr_en && addr == `HPEM_OFS_EXT_BUS_OFF)
		begin
			ext_bus_power_port_off <= wdata[`HPEM_PORT_HI:`HPEM_PORT_LO];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			port_remap_first_pair <= `HPEM_RST_REMAP;
		end
		else if (wr_en && addr == `HPEM_OFS_REMAP_PAIR)
		begin
			port_remap_first_pair <= wdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			port_remap_third <= `HPEM_RST_REMAP;
		end
		else if (wr_en && addr == `HPEM_OFS_REMAP_THIRD)
		begin
			port_remap_third <= wdata;
		end
	end

	// ====================================================================
	// Port enable and fixed-device selection
	hpem_ports_t self_off;
	hpem_ports_t bus_off;
	hpem_ports_t next_enable;
	hpem_ports_t next_fixed;
	hpem_ports_t strap_off;

	always_comb
	begin
		// The strap field disables from the top port downward.
		strap_off = hpem_low_ports(off_sync2);
		strap_off = {strap_off[0], strap_off[1], strap_off[2]};
		if (strap_default_sel)
		begin
			self_off   = strap_off;
			bus_off    = strap_off;
			next_fixed = hpem_low_ports(fix_sync2);
		end
		else
		begin
			self_off   = self_power_port_off_mask | ext_self_power_port_off;
			bus_off    = bus_power_port_off_mask | ext_bus_power_port_off;
			next_fixed = fixed_device_port_mask;
		end
		next_enable = sp_sync2 ? ~self_off : ~bus_off;
	end

	hpem_ports_t enable;
	hpem_ports_t fixed;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			enable <= 3'h0;
			fixed  <= 3'h0;
		end
		else
		begin
			enable <= next_enable;
			fixed  <= next_fixed & next_enable;
		end
	end

	// ====================================================================
	// Logical numbering
	hpem_lmap_t remap;
	hpem_lmap_t lmap;
	logic [1:0] count;

	assign remap.p1 = port_remap_first_pair[`HPEM_MAP1_HI:`HPEM_MAP1_LO];
	assign remap.p2 = port_remap_first_pair[`HPEM_MAP2_HI:`HPEM_MAP2_LO];
	assign remap.p3 = port_remap_third[`HPEM_MAP1_HI:`HPEM_MAP1_LO];

	hpem_renumber u_renumber (
		.clk        (clk),
		.nrst       (nrst),
		.enable     (enable),
		.remap_mode (explicit_remap_select),
		.remap      (remap),
		.lmap       (lmap),
		.count      (count)
	);

	assign port_report.enable = enable;
	assign port_report.fixed  = fixed;
	assign port_report.count  = count;
	assign port_report.lmap   = lmap;

	// ====================================================================
	// Read port
	logic [7:0] next_rdata;

	always_comb
	begin
		next_rdata = 8'h00;
		if (addr == `HPEM_OFS_NUMBERING_CFG)
		begin
			next_rdata = {4'h0, explicit_remap_select, 3'h0};
		end
		else if (addr == `HPEM_OFS_FIXED_MASK)
		begin
			next_rdata = hpem_mask_read(fixed_device_port_mask);
		end
		else if (addr == `HPEM_OFS_SELF_OFF_MASK)
		begin
			next_rdata = hpem_mask_read(self_power_port_off_mask);
		end
		else if (addr == `HPEM_OFS_BUS_OFF_MASK)
		begin
			next_rdata = hpem_mask_read(bus_power_port_off_mask);
		end
		else if (addr == `HPEM_OFS_EXT_SELF_OFF)
		begin
			next_rdata = hpem_mask_read(ext_self_power_port_off);
		end
		else if (addr == `HPEM_OFS_EXT_BUS_OFF)
		begin
			next_rdata = hpem_mask_read(ext_bus_power_port_off);
		end
		else if (addr == `HPEM_OFS_REMAP_PAIR)
		begin
			next_rdata = port_remap_first_pair;
		end
		else if (addr == `HPEM_OFS_REMAP_THIRD)
		begin
			next_rdata = port_remap_third;
		end
		else if (addr == `HPEM_OFS_DEFAULT_CTRL)
		begin
			next_rdata = {7'h00, strap_default_sel};
		end
		else if (addr == `HPEM_OFS_STATUS)
		begin
			// Status shows what is in effect now, not what was last written.
			next_rdata = {explicit_remap_select, sp_sync2, count, enable, 1'b0};
		end
	end

	// Read data stand for one cycle only and are zero otherwise.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			rdata <= `HPEM_RST_RDATA;
		end
		else if (rd_en)
		begin
			rdata <= next_rdata;
		end
		else
		begin
			rdata <= `HPEM_RST_RDATA;
		end
	end

endmodule : hpem_top

// ==== test/hpem_top_sva.sv ====
// Concurrent checks on the ports of the hub port map configuration block.
`timescale 1ns/1ps
// ====================================================================
// Checker
module hpem_top_chk
	import hpem_pkg::*;
(
	input wire logic         clk,
	input wire logic         nrst,
	input wire logic [15:0]  addr,
	input wire logic         rd_en,
	input wire logic [7:0]   rdata,
	input wire hpem_report_t port_report
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire hpem_lmap_t m = port_report.lmap;
	wire [1:0] nz = 2'((m.p1 != 4'h0) + (m.p2 != 4'h0) + (m.p3 != 4'h0));
	chk_rdata_idle: assert property (rdata != 8'h00 |-> $past(rd_en))
		else $error("read data outside read cycle");
	chk_cfg_rsvd: assert property ($past(rd_en) && $past(addr) == 16'h00E6 |-> (rdata & 8'hF7) == 8'h00)
		else $error("numbering byte reserved bits set");
	chk_fixed_rsvd: assert property ($past(rd_en) && $past(addr) == 16'h00E7 |-> (rdata & 8'hF1) == 8'h00)
		else $error("fixed mask reserved bits set");
	chk_off_rsvd: assert property ($past(rd_en) && $past(addr) inside {16'h00E8, 16'h00E9} |-> !(|(rdata & 8'hF1)))
		else $error("off mask reserved bits set");
	chk_unmapped_zero: assert property ($past(rd_en) && $past(addr) == 16'h1234 |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_count_match: assert property (port_report.count == nz)
		else $error("count differs from reported ports");
	chk_fixed_enabled: assert property ((port_report.fixed & ~port_report.enable) == 3'h0)
		else $error("fixed flag on disabled port");
	chk_off_unmapped: assert property (!$past(port_report.enable[0]) |-> m.p1 == 4'h0)
		else $error("disabled port still numbered");
	cov_read: cover property (rd_en ##1 rdata != 8'h00);
	cov_all_on: cover property (port_report.count == 2'h3);
	cov_all_off: cover property (port_report.enable == 3'h0);
endmodule : hpem_top_chk
bind hpem_top hpem_top_chk u_chk (.clk(clk), .nrst(nrst), .addr(addr), .rd_en(rd_en), .rdata(rdata),
	.port_report(port_report));

// ==== test/hpem_host_model.sv ====
// Upstream host model that counts the downstream ports it is offered.
`timescale 1ns/1ps
// ====================================================================
// Host model
module hpem_host_model
	import hpem_pkg::*;
(
	input wire hpem_report_t port_report,
	output logic [1:0]       seen
);
	// The host only enumerates ports that carry a nonzero logical number.
	always_comb
	begin
		// A fixed port is enumerated like any other; its device answers for its own descriptors.
		seen = 2'((port_report.lmap.p1 != 4'h0) + (port_report.lmap.p2 != 4'h0)
			+ (port_report.lmap.p3 != 4'h0));
	end
endmodule : hpem_host_model

// ==== test/test_hpem_top.sv ====
// Register and port report tests of the hub port map configuration block.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %0t got %h want %h", $time, g, e); end end
// ====================================================================
// Bench
module test_hpem_top
	import hpem_pkg::*;
;
	logic clk, nrst, wr_en, rd_en, spp;
	logic [15:0] addr;
	logic [7:0]  wdata, rv;
	logic [7:0]  rdata;
	logic [1:0]  sf, so, seen;
	hpem_report_t rep, er;
	int err_total, compares;
	logic [15:0] rst_a [4] = '{16'h300A, 16'h300B, 16'h30FB, 16'h30FC};
	hpem_top dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .self_powered_pin(spp), .strap_fixed_device_bits(sf), .strap_port_off_bits(so),
		.port_report(rep));
	hpem_host_model host (.port_report(rep), .seen(seen));
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a; wdata <= d; wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task rd(input logic [15:0] a);
		@(posedge clk);
		addr <= a; rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 rv = rdata;
	endtask : rd
	// Report settles within four edges of a change; six leaves margin.
	task settle;
		repeat (6) @(posedge clk);
		#1;
	endtask : settle
	function automatic hpem_report_t exp_rep(input logic [2:0] en, input logic [2:0] fx, input logic [11:0] mp);
		hpem_report_t r;
		logic [1:0] c;
		c = 2'h0;
		r.lmap = hpem_lmap_t'(mp);
		for (int i = 0; i < 3; i++)
		begin
			// A disabled port is never reported, in either numbering mode.
			if (!en[i]) r.lmap[4*i+:4] = 4'h0;
			else if (mp == 12'h000) begin c++; r.lmap[4*i+:4] = {2'h0, c}; end
			else if (mp[4*i+:4] != 4'h0) c++;
		end
		r.enable = en; r.fixed = fx & en; r.count = c;
		return r;
	endfunction : exp_rep
	task test_done;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	initial begin clk = 1'b0; forever #5 clk = ~clk; end
	initial
	begin
		repeat (5000) @(posedge clk);
		err_total++;
		test_done;
	end
	initial
	begin
		nrst = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 16'h0000; wdata = 8'h00;
		spp = 1'b1; sf = 2'h0; so = 2'h0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		foreach (rst_a[i]) begin rd(rst_a[i]); `CHK(rv, 8'h00) end
		rd(16'h30F0); `CHK(rv, 8'h01)
		`CHK(rep, exp_rep(3'h7, 3'h0, 12'h000))
		wr(16'h30F0, 8'h00);
		wr(16'h00E6, 8'hFF); rd(16'h00E6); `CHK(rv, 8'h08)
		wr(16'h00E6, 8'h00);
		wr(16'h00E7, 8'hFF); rd(16'h00E7); `CHK(rv, 8'h0E)
		wr(16'h1234, 8'hFF); rd(16'h1234); `CHK(rv, 8'h00)
		wr(16'h00E7, 8'h02);
		for (int k = 0; k < 8; k++)
		begin
			wr(16'h00E8, {4'hF, 3'(k), 1'b1});
			rd(16'h00E8); `CHK(rv, ({4'h0, 3'(k), 1'b0}))
			settle;
			er = exp_rep(~3'(k), 3'h1, 12'h000);
			`CHK(rep, er)
			`CHK(seen, er.count)
		end
		wr(16'h00E8, 8'h00); wr(16'h00E7, 8'h06); settle;
		`CHK(rep, exp_rep(3'h7, 3'h3, 12'h000))
		@(posedge clk); spp <= 1'b0; wr(16'h00E9, 8'h02); settle;
		`CHK(rep.enable, 3'h6)
		rd(16'h00E9); `CHK(rv, 8'h02)
		rd(16'h30F1); `CHK(rv, 8'h2C)
		wr(16'h00E9, 8'h00); wr(16'h300B, 8'h08); settle;
		`CHK(rep, exp_rep(3'h3, 3'h3, 12'h000))
		@(posedge clk); spp <= 1'b1; wr(16'h30FB, 8'h13); wr(16'h30FC, 8'h02); wr(16'h00E6, 8'h08); settle;
		`CHK(rep, exp_rep(3'h7, 3'h3, 12'h213))
		rd(16'h30F1); `CHK(rv, 8'hFE)
		wr(16'h00E8, 8'h04); settle;
		`CHK(rep, exp_rep(3'h5, 3'h3, 12'h213))
		wr(16'h00E6, 8'h00); wr(16'h30F0, 8'h01); so <= 2'h1; sf <= 2'h2; settle;
		`CHK(rep.enable, 3'h3)
		`CHK(rep.fixed, 3'h3)
		@(posedge clk); nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rd(16'h30FB); `CHK(rv, 8'h00)
		rd(16'h00E7); `CHK(rv, 8'h00)
		test_done;
	end
endmodule : test_hpem_top
